// ---- rtl/srsr_defs.svh ----
// Register offsets, widths and reset values of the sensor result and status slice.
`ifndef SRSR_DEFS_SVH
`define SRSR_DEFS_SVH
`define SRSR_ADDR_W 8
`define SRSR_DATA_W 8
`define SRSR_OFF_PROX3_LOW 8'h2A
`define SRSR_OFF_PROX3_HIGH 8'h2B
`define SRSR_OFF_AUX_LOW 8'h2C
`define SRSR_OFF_AUX_HIGH 8'h2D
`define SRSR_OFF_MAILBOX 8'h2E
`define SRSR_OFF_PWR_STAT 8'h30
`define SRSR_OFF_KEY_B3 8'h3B
`define SRSR_OFF_KEY_B2 8'h3C
`define SRSR_OFF_KEY_B1 8'h3D
`define SRSR_OFF_KEY_B0 8'h3E
`define SRSR_RST_BYTE 8'h00
`define SRSR_RST_WORD 16'h0000
`define SRSR_RST_KEY 32'h0000_0000
`define SRSR_BIT_SLEEP 0
`define SRSR_BIT_SUSPEND 1
`define SRSR_BIT_AWAKE 2
`endif

// ---- rtl/srsr_pkg.sv ----
// Types shared by the sensor result and status slice.
package srsr_pkg;
    typedef enum logic [1:0] {
        SRSR_PWR_SLEEP,
        SRSR_PWR_SUSPEND,
        SRSR_PWR_AWAKE
    } srsr_pwr_e;
endpackage : srsr_pkg

// ---- rtl/srsr_wr_if.sv ----
// Write strobe bundle from the register decoder to the result word store.
`timescale 1ns/1ps
`default_nettype none
interface srsr_wr_if;
    logic [7:0] addr;
    logic [7:0] data;
    logic host_we;
    logic seq_we;
    logic [15:0] seq_prox3;
    logic [15:0] seq_aux;
    logic [15:0] prox3;
    logic [15:0] aux;
    modport ctrl (output addr, data, host_we, seq_we, seq_prox3, seq_aux, input prox3, aux);
    modport store (input addr, data, host_we, seq_we, seq_prox3, seq_aux, output prox3, aux);
endinterface : srsr_wr_if
`default_nettype wire

// ---- rtl/srsr_result_store.sv ----
// Result word store for the third proximity channel and the auxiliary channel.
`timescale 1ns/1ps
`default_nettype none
`include "srsr_defs.svh"
module srsr_result_store (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    srsr_wr_if.store wr
);
    logic [15:0] prox3_reg;
    logic [15:0] prox3_next;
    logic [15:0] aux_reg;
    logic [15:0] aux_next;

    // A finished measurement replaces both words; a host write in that
    // same cycle loses, since the new result is what the host must see.
    always_comb begin
        prox3_next = prox3_reg;
        aux_next = aux_reg;
        if (wr.seq_we) begin
            prox3_next = wr.seq_prox3; // see R1
            aux_next = wr.seq_aux; // see R2
        end else if (wr.host_we) begin
            if (wr.addr == `SRSR_OFF_PROX3_LOW) begin
                prox3_next[7:0] = wr.data; // see R1
            end else if (wr.addr == `SRSR_OFF_PROX3_HIGH) begin
                prox3_next[15:8] = wr.data;
            end else if (wr.addr == `SRSR_OFF_AUX_LOW) begin
                aux_next[7:0] = wr.data; // see R2
            end else if (wr.addr == `SRSR_OFF_AUX_HIGH) begin
                aux_next[15:8] = wr.data;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prox3_reg <= `SRSR_RST_WORD; // see R7
            aux_reg <= `SRSR_RST_WORD;
        end else if (clk_en) begin
            prox3_reg <= prox3_next;
            aux_reg <= aux_next;
        end
    end

    assign wr.prox3 = prox3_reg;
    assign wr.aux = aux_reg;
endmodule : srsr_result_store
`default_nettype wire

// ---- rtl/srsr_regs.sv ----
// Host register slice: proximity 3 and auxiliary results, mailbox, power status, key.
// Function
// R1: Third proximity result is a 16-bit word, low byte 0x2A, high 0x2B.
// R2: Auxiliary/UV result is a 16-bit word, low byte 0x2C, high 0x2D.
// R3: Host reads each result after interrupt and before next measurement ends.
// R4: Register 0x2E is the mailbox returning a requested parameter to the host.
// R5: Power status bit 2 means awake, bit 1 means waiting for measurement.
// R6: Power status bit 0 means lowest power state; bits 7 to 3 reserved.
// R7: All result, mailbox and status registers reset to zero.
// R8: Host reaches parameters only through fetch and write commands and mailbox.
// R9: Key spans 0x3B to 0x3E, most significant byte first, no effect.
`timescale 1ns/1ps
`default_nettype none
`include "srsr_defs.svh"
module srsr_regs (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic meas_done,
    input wire logic [15:0] meas_prox3,
    input wire logic [15:0] meas_aux,
    input wire logic param_valid,
    input wire logic [7:0] param_value,
    input wire srsr_pkg::srsr_pwr_e pwr_state,
    output logic [31:0] reserved_analog_key
);
    srsr_wr_if wr ();

    logic [7:0] mailbox_reg;
    logic [7:0] mailbox_next;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [31:0] key_reg;
    logic [31:0] key_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;

    function automatic logic [7:0] pwr_bits(input srsr_pkg::srsr_pwr_e st);
        logic [7:0] b;
        b = `SRSR_RST_BYTE; // see R6
        case (st)
            srsr_pkg::SRSR_PWR_AWAKE: b[`SRSR_BIT_AWAKE] = 1'b1; // see R5
            srsr_pkg::SRSR_PWR_SUSPEND: b[`SRSR_BIT_SUSPEND] = 1'b1;
            srsr_pkg::SRSR_PWR_SLEEP: b[`SRSR_BIT_SLEEP] = 1'b1; // see R6
            default: b = `SRSR_RST_BYTE;
        endcase
        return b;
    endfunction : pwr_bits

    assign wr.addr = reg_addr;
    assign wr.data = reg_wdata;
    assign wr.host_we = reg_wr;
    assign wr.seq_we = meas_done; // see R3
    assign wr.seq_prox3 = meas_prox3;
    assign wr.seq_aux = meas_aux;

    srsr_result_store u_store (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .wr(wr)
    );

    // The sequencer's reply wins over a host write to the mailbox, so a
    // fetched parameter is not lost to a stray write in the same cycle.
    always_comb begin
        mailbox_next = mailbox_reg;
        key_next = key_reg;
        status_next = pwr_bits(pwr_state);
        if (param_valid) begin
            mailbox_next = param_value; // see R4
        end else if (reg_wr && reg_addr == `SRSR_OFF_MAILBOX) begin
            mailbox_next = reg_wdata;
        end
        if (reg_wr) begin
            if (reg_addr == `SRSR_OFF_KEY_B3) begin
                key_next[31:24] = reg_wdata; // see R9
            end else if (reg_addr == `SRSR_OFF_KEY_B2) begin
                key_next[23:16] = reg_wdata;
            end else if (reg_addr == `SRSR_OFF_KEY_B1) begin
                key_next[15:8] = reg_wdata;
            end else if (reg_addr == `SRSR_OFF_KEY_B0) begin
                key_next[7:0] = reg_wdata;
            end
        end
    end

    // Reads return the value held before any write of the same cycle.
    always_comb begin
        rvalid_next = reg_rd;
        rdata_next = rdata_reg;
        if (reg_rd) begin
            if (reg_addr == `SRSR_OFF_PROX3_LOW) begin
                rdata_next = wr.prox3[7:0]; // see R1
            end else if (reg_addr == `SRSR_OFF_PROX3_HIGH) begin
                rdata_next = wr.prox3[15:8];
            end else if (reg_addr == `SRSR_OFF_AUX_LOW) begin
                rdata_next = wr.aux[7:0]; // see R2
            end else if (reg_addr == `SRSR_OFF_AUX_HIGH) begin
                rdata_next = wr.aux[15:8];
            end else if (reg_addr == `SRSR_OFF_MAILBOX) begin
                rdata_next = mailbox_reg; // see R4
            end else if (reg_addr == `SRSR_OFF_PWR_STAT) begin
                rdata_next = status_reg; // see R5
            end else if (reg_addr == `SRSR_OFF_KEY_B3) begin
                rdata_next = key_reg[31:24]; // see R9
            end else if (reg_addr == `SRSR_OFF_KEY_B2) begin
                rdata_next = key_reg[23:16];
            end else if (reg_addr == `SRSR_OFF_KEY_B1) begin
                rdata_next = key_reg[15:8];
            end else if (reg_addr == `SRSR_OFF_KEY_B0) begin
                rdata_next = key_reg[7:0];
            end else begin
                rdata_next = `SRSR_RST_BYTE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mailbox_reg <= `SRSR_RST_BYTE; // see R7
            status_reg <= `SRSR_RST_BYTE;
            key_reg <= `SRSR_RST_KEY;
            rdata_reg <= `SRSR_RST_BYTE;
            rvalid_reg <= 1'b0;
        end else if (clk_en) begin
            mailbox_reg <= mailbox_next;
            status_reg <= status_next;
            key_reg <= key_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    // The key is only exported; nothing in this slice acts on it.
    assign reserved_analog_key = key_reg; // see R9
endmodule : srsr_regs
`default_nettype wire

// ---- verif/srsr_regs_chk.sv ----
// Port checker for the sensor result and status register slice.
`timescale 1ns/1ps
`default_nettype none
module srsr_regs_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic meas_done,
    input wire logic [15:0] meas_prox3,
    input wire logic [15:0] meas_aux,
    input wire logic param_valid,
    input wire logic [7:0] param_value,
    input wire srsr_pkg::srsr_pwr_e pwr_state,
    input wire logic [31:0] reserved_analog_key
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire rd_ok = reg_rd & clk_en;
    wire wr_ok = reg_wr & clk_en;
    read_answer_a: assert property (rd_ok |=> reg_rvalid) else $error("no answer");
    prox3_low_a: assert property (meas_done & clk_en ##1 !meas_done ##1
        rd_ok & reg_addr == 8'h2A |=> reg_rdata == $past(meas_prox3[7:0], 3)) else $error("p3");
    aux_high_a: assert property (meas_done & clk_en ##1 !meas_done ##1
        rd_ok & reg_addr == 8'h2D |=> reg_rdata == $past(meas_aux[15:8], 3)) else $error("aux");
    mailbox_read_a: assert property (param_valid & clk_en ##1 !param_valid ##1
        rd_ok & reg_addr == 8'h2E |=> reg_rdata == $past(param_value, 3)) else $error("mbox");
    status_bits_a: assert property (rd_ok && reg_addr == 8'h30 && $past(clk_en) &&
        $past(nrst) |=> reg_rdata == 8'h01 << $past(pwr_state, 2)) else $error("status");
    reset_zero_a: assert property (disable iff (1'b0) $rose(nrst) |->
        reg_rdata == 8'h00 && !reg_rvalid && reserved_analog_key == 32'h0) else $error("rst");
    key_msb_a: assert property (wr_ok && reg_addr == 8'h3B |=>
        reserved_analog_key[31:24] == $past(reg_wdata)) else $error("key msb");
    key_hold_a: assert property (!wr_ok |=> $stable(reserved_analog_key)) else $error("key");
    cover property (rd_ok && reg_addr == 8'h30);
    cover property (meas_done && clk_en);
    cover property (wr_ok && reg_addr == 8'h3E);
endmodule : srsr_regs_chk
bind srsr_regs srsr_regs_chk chk_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .meas_done(meas_done),
    .meas_prox3(meas_prox3), .meas_aux(meas_aux), .param_valid(param_valid),
    .param_value(param_value), .pwr_state(pwr_state), .reserved_analog_key(reserved_analog_key));
`default_nettype wire

// ---- verif/srsr_host_model.sv ----
// Host model issuing single register reads and writes at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module srsr_host_model (
    input wire logic sys_clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Write data is inverted once released, so a stale byte is never taken as valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // Results are read right after each load and parameters only via the mailbox.
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask : rd
endmodule : srsr_host_model
`default_nettype wire

// ---- verif/srsr_regs_tb.sv ----
// Self-checking testbench for the sensor result and status register slice.
`timescale 1ns/1ps
`default_nettype none
module srsr_regs_tb;
    logic sys_clk, nrst, clk_en, reg_wr, reg_rd, reg_rvalid, meas_done, param_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, param_value;
    logic [15:0] meas_prox3, meas_aux;
    logic [31:0] key;
    srsr_pkg::srsr_pwr_e pwr_state;
    int err_count, comparisons;
    logic [7:0] offs[9] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h3B, 8'h3C, 8'h3D, 8'h3E};
    logic [7:0] res[5] = '{8'h1C, 8'hA5, 8'h07, 8'h3E, 8'hC3};
    srsr_host_model host_u (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    srsr_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .meas_done(meas_done), .meas_prox3(meas_prox3),
        .meas_aux(meas_aux), .param_valid(param_valid), .param_value(param_value),
        .pwr_state(pwr_state), .reserved_analog_key(key));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a);
        chk({31'h0, reg_rvalid}, 32'h0000_0001);
        chk({24'h0, reg_rdata}, {24'h0, e});
    endtask : rchk
    task automatic load(input logic [15:0] p, input logic [15:0] x, input logic [7:0] v);
        @(negedge sys_clk);
        {meas_done, param_valid, meas_prox3, meas_aux, param_value} = {2'b11, p, x, v};
        @(negedge sys_clk);
        {meas_done, param_valid} = 2'b00;
    endtask : load
    task automatic end_of_test;
        $display("err_count=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        #20000;
        err_count++;
        end_of_test();
    end
    initial begin
        {nrst, clk_en, meas_done, param_valid, meas_prox3, meas_aux, param_value} = '0;
        pwr_state = srsr_pkg::SRSR_PWR_SLEEP;
        err_count = 0;
        comparisons = 0;
        clk_en = 1'b1;
        repeat (5) @(negedge sys_clk);
        nrst = 1'b1;
        foreach (offs[i]) rchk(offs[i], 8'h00);
        chk(key, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            pwr_state = srsr_pkg::srsr_pwr_e'(i);
            host_u.wr(8'h30, 8'hFF);
            rchk(8'h30, 8'h01 << i);
        end
        for (int i = 0; i < 5; i++) begin
            load(16'hA51C, 16'h3E07, 8'hC3);
            rchk(8'h2A + 8'(i), res[i]);
        end
        for (int i = 0; i < 4; i++) host_u.wr(8'h3B + 8'(i), 8'h11 * 8'(i + 1));
        chk(key, 32'h1122_3344);
        rchk(8'h3E, 8'h44);
        rchk(8'h2F, 8'h00);
        clk_en = 1'b0;
        load(16'h0000, 16'h0000, 8'h00);
        clk_en = 1'b1;
        rchk(8'h2A, 8'h1C);
        nrst = 1'b0;
        @(negedge sys_clk);
        nrst = 1'b1;
        rchk(8'h2E, 8'h00);
        chk(key, 32'h0000_0000);
        end_of_test();
    end
endmodule : srsr_regs_tb
`default_nettype wire
